// ==== include/status_pkg.sv ====
// Constants, command codes and carrier structs of the status reporting core
package status_pkg;

    typedef logic signed [15:0] code_t;

    // Event latch bit positions
    localparam int EV_OPC = 0;
    localparam int EV_QYE = 2;
    localparam int EV_DDE = 3;
    localparam int EV_EXE = 4;
    localparam int EV_CME = 5;
    localparam int EV_PON = 7;

    // Status byte bit positions
    localparam int STB_EVQ = 2;
    localparam int STB_QUES = 3;
    localparam int STB_MAV = 4;
    localparam int STB_ESB = 5;
    localparam int STB_RQS = 6;

    // Reset values and write masks
    localparam logic [7:0] ESR_RESET = 8'h80;
    localparam logic [7:0] SRE_RESET = 8'h00;
    localparam logic [7:0] ESE_RESET = 8'h00;
    localparam logic [7:0] SRE_WR_MASK = 8'hBF;

    // Queue depth and error codes
    localparam int EVQ_DEPTH = 10;
    localparam code_t CODE_NONE = 16'sh0000;
    localparam code_t CODE_MNEM_LONG = -16'sh0070;
    localparam code_t CODE_EXP_LARGE = -16'sh007B;
    localparam code_t CODE_DIGITS = -16'sh007C;
    localparam code_t CODE_SUFFIX_LONG = -16'sh0086;
    localparam code_t CODE_CHAR_LONG = -16'sh0090;
    localparam code_t CODE_EXPR = -16'sh00AA;
    localparam code_t CODE_TOO_MUCH = -16'sh00DF;
    localparam code_t CODE_PROTECTED = -16'sh0102;
    localparam code_t CODE_CFG_LOST = -16'sh013B;
    localparam code_t CODE_SELFTEST = -16'sh014A;
    localparam code_t CODE_OVERFLOW = -16'sh015E;

    // Group bounds, most negative first
    localparam code_t CME_LO = -16'sh00C7;
    localparam code_t CME_HI = -16'sh0064;
    localparam code_t EXE_LO = -16'sh012B;
    localparam code_t EXE_HI = -16'sh00C8;
    localparam code_t DDE_LO = -16'sh018F;
    localparam code_t DDE_HI = -16'sh012C;
    localparam code_t QYE_LO = -16'sh01F3;
    localparam code_t QYE_HI = -16'sh0190;

    // Parser limits
    localparam logic [15:0] MNEM_MAX = 16'h000C;
    localparam logic [15:0] SUFFIX_MAX = 16'h000C;
    localparam logic [15:0] CHAR_MAX = 16'h000C;
    localparam logic [15:0] EXP_MAX = 16'h7D00;
    localparam logic [15:0] DIGITS_MAX = 16'h00FF;
    localparam logic [15:0] RANGES_MAX = 16'h0006;
    localparam logic [15:0] WAVE_CAP = 16'hFFFF;

    typedef enum logic [3:0] {
        CMD_NONE = 4'h0,
        CMD_SRE_WR = 4'h1,
        CMD_SRE_RD = 4'h2,
        CMD_ESE_WR = 4'h3,
        CMD_ESE_RD = 4'h4,
        CMD_ESR_RD = 4'h5,
        CMD_STB_RD = 4'h6,
        CMD_POLL = 4'h7,
        CMD_CLS = 4'h8,
        CMD_OPC = 4'h9,
        CMD_ERR_RD = 4'hA
    } cmd_e;

    typedef enum logic [3:0] {
        CHK_MNEMONIC = 4'h0,
        CHK_SUFFIX = 4'h1,
        CHK_CHARDATA = 4'h2,
        CHK_EXPONENT = 4'h3,
        CHK_DIGITS = 4'h4,
        CHK_RANGES = 4'h5,
        CHK_PROTECT = 4'h6,
        CHK_WAVE_SIZE = 4'h7,
        CHK_CFG_MEM = 4'h8,
        CHK_SELFTEST = 4'h9
    } chk_e;

    typedef struct packed {
        cmd_e op;
        logic [7:0] arg;
    } cmd_s;

    typedef struct packed {
        logic valid;
        chk_e kind;
        logic [15:0] value;
    } chk_s;

    typedef struct packed {
        logic valid;
        code_t code;
    } err_s;

    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } rsp_s;

endpackage : status_pkg

// ==== logic/status_event_reporting.sv ====
// Status byte, standard event latch, enables and error queue
`timescale 1ns/1ps
module status_event_reporting
    import status_pkg::*;
#(
    parameter int DEPTH = EVQ_DEPTH,
    parameter logic [15:0] WAVE_CAPACITY = WAVE_CAP
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire cmd_s cmd,
    input wire err_s err,
    input wire chk_s chk,
    input wire logic query_error,
    input wire logic mav,
    input wire logic ques,
    output rsp_s rsp,
    output logic [7:0] status_byte,
    output logic srq
);

    // Pointer and count widths; the count needs one value more than a pointer
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    // Ring pointer and fill level
    typedef logic [PW-1:0] ptr_t;
    typedef logic [CW-1:0] cnt_t;

    // All block state, registered as one word
    typedef struct packed {
        logic [DEPTH-1:0][15:0] fifo;
        ptr_t head;
        cnt_t count;
        logic [7:0] esr;
        logic [7:0] service_request_mask;
        logic [7:0] ese;
        logic reason;
        logic srq;
        logic [7:0] stb;
        rsp_s rsp;
    } state_s;

    // Current and next state
    state_s s_q;
    state_s s_d;

    // Slot index of head plus an offset, wrapped around the ring
    function automatic ptr_t ring(input ptr_t base, input cnt_t off);
        logic [CW:0] sum;
        sum = {{(CW + 1 - PW){1'b0}}, base} + {1'b0, off};
        // One wrap is enough, as the offset never exceeds the depth
        if (sum >= (CW + 1)'(DEPTH))
        begin
            sum = sum - (CW + 1)'(DEPTH);
        end
        return PW'(sum);
    endfunction : ring

    // Event bits implied by one error code
    function automatic logic [7:0] code_events(input code_t c);
        logic [7:0] ev;
        ev = 8'h00;
        // Syntax group
        if (c >= CME_LO && c <= CME_HI)
        begin
            ev[EV_CME] = 1'b1;
        end
        // Execution group
        if (c >= EXE_LO && c <= EXE_HI)
        begin
            ev[EV_EXE] = 1'b1;
        end
        // Device condition group
        if (c >= DDE_LO && c <= DDE_HI)
        begin
            ev[EV_DDE] = 1'b1;
        end
        // Output queue group
        if (c >= QYE_LO && c <= QYE_HI)
        begin
            ev[EV_QYE] = 1'b1;
        end
        return ev;
    endfunction : code_events

    // Parser limit checks turned into codes
    logic chk_hit;
    code_t chk_code;

    always_comb
    begin
        chk_hit = 1'b0;
        chk_code = CODE_NONE;
        unique case (chk.kind)
            // Length and size kinds fault past their limit
            CHK_MNEMONIC:
            begin
                chk_hit = chk.value > MNEM_MAX;
                chk_code = CODE_MNEM_LONG;
            end
            CHK_SUFFIX:
            begin
                chk_hit = chk.value > SUFFIX_MAX;
                chk_code = CODE_SUFFIX_LONG;
            end
            CHK_CHARDATA:
            begin
                chk_hit = chk.value > CHAR_MAX;
                chk_code = CODE_CHAR_LONG;
            end
            CHK_EXPONENT:
            begin
                chk_hit = chk.value > EXP_MAX;
                chk_code = CODE_EXP_LARGE;
            end
            CHK_DIGITS:
            begin
                chk_hit = chk.value > DIGITS_MAX;
                chk_code = CODE_DIGITS;
            end
            CHK_RANGES:
            begin
                chk_hit = chk.value > RANGES_MAX;
                chk_code = CODE_EXPR;
            end
            // Flag kinds fault when bit 0 is set; wave size faults past its capacity
            CHK_PROTECT:
            begin
                chk_hit = chk.value[0];
                chk_code = CODE_PROTECTED;
            end
            CHK_WAVE_SIZE:
            begin
                chk_hit = chk.value > WAVE_CAPACITY;
                chk_code = CODE_TOO_MUCH;
            end
            CHK_CFG_MEM:
            begin
                chk_hit = chk.value[0];
                chk_code = CODE_CFG_LOST;
            end
            CHK_SELFTEST:
            begin
                chk_hit = chk.value[0];
                chk_code = CODE_SELFTEST;
            end
            default:
            begin
                chk_hit = 1'b0;
                chk_code = CODE_NONE;
            end
        endcase
        chk_hit = chk_hit & chk.valid;
    end

    // Next state of the whole block
    always_comb
    begin
        logic push;
        code_t push_code;
        logic pop;
        logic clear_all;
        logic esr_rd;
        logic [7:0] ev_set;
        logic [7:0] summary;
        logic reason;
        ptr_t hd;
        cnt_t cnt;

        // Locals start from known values so no path leaves a latch
        push = 1'b0;
        push_code = CODE_NONE;
        pop = 1'b0;
        clear_all = 1'b0;
        esr_rd = 1'b0;
        ev_set = 8'h00;
        summary = 8'h00;
        reason = 1'b0;
        hd = '0;
        cnt = '0;

        s_d = s_q;
        s_d.rsp.valid = 1'b0;
        s_d.rsp.data = s_q.rsp.data;

        // A failed limit check outranks a raw report in the same cycle
        push = chk_hit | err.valid;
        push_code = chk_hit ? chk_code : err.code;
        clear_all = cmd.op == CMD_CLS;
        esr_rd = cmd.op == CMD_ESR_RD;
        pop = (cmd.op == CMD_ERR_RD) && (s_q.count != '0);

        // Events raised this cycle; bits 1, 6 and 7 have no source
        ev_set = 8'h00;
        if (push)
        begin
            ev_set = code_events(push_code);
        end
        if (query_error)
        begin
            ev_set[EV_QYE] = 1'b1;
        end
        if (cmd.op == CMD_OPC)
        begin
            ev_set[EV_OPC] = 1'b1;
        end

        // Clear first, then set, so a new event is never lost
        s_d.esr = ((clear_all || esr_rd) ? 8'h00 : s_q.esr) | ev_set;

        // Queue: clear or pop, then push at the tail
        hd = s_q.head;
        cnt = s_q.count;
        if (clear_all)
        begin
            hd = '0;
            cnt = '0;
        end
        else if (pop)
        begin
            hd = ring(hd, cnt_t'(1));
            cnt = cnt - cnt_t'(1);
        end
        // Push lands at the tail, or marks the loss when full
        if (push)
        begin
            if (cnt == FULL)
            begin
                // Oldest entries survive; newest slot reports the loss
                s_d.fifo[ring(hd, cnt - cnt_t'(1))] = CODE_OVERFLOW;
            end
            else
            begin
                s_d.fifo[ring(hd, cnt)] = push_code;
                cnt = cnt + cnt_t'(1);
            end
        end
        // Commit the new pointers
        s_d.head = hd;
        s_d.count = cnt;

        // Status summary from the registered state and the live mav and ques inputs
        summary = 8'h00;
        summary[STB_EVQ] = s_q.count != '0;
        summary[STB_QUES] = ques;
        summary[STB_MAV] = mav;
        summary[STB_ESB] = |(s_q.esr & s_q.ese);
        reason = |(summary & s_q.service_request_mask & SRE_WR_MASK);
        s_d.reason = reason;
        s_d.stb = summary;
        s_d.stb[STB_RQS] = reason;

        // Request latches on a new reason; a poll clears it, set wins
        s_d.srq = (s_q.srq & (cmd.op != CMD_POLL)) | (reason & ~s_q.reason);

        // Command decode
        unique case (cmd.op)
            CMD_SRE_WR:
            begin
                s_d.service_request_mask = cmd.arg & SRE_WR_MASK;
            end
            CMD_SRE_RD:
            begin
                s_d.rsp.valid = 1'b1;
                s_d.rsp.data = {8'h00, s_q.service_request_mask};
            end
            CMD_ESE_WR:
            begin
                s_d.ese = cmd.arg;
            end
            CMD_ESE_RD:
            begin
                s_d.rsp.valid = 1'b1;
                s_d.rsp.data = {8'h00, s_q.ese};
            end
            CMD_ESR_RD:
            begin
                s_d.rsp.valid = 1'b1;
                s_d.rsp.data = {8'h00, s_q.esr};
            end
            CMD_STB_RD:
            begin
                // Query form shows bit 6 while any reason exists
                s_d.rsp.valid = 1'b1;
                s_d.rsp.data = {8'h00, s_q.stb};
            end
            CMD_POLL:
            begin
                // Poll form shows the latched request, then drops it
                s_d.rsp.valid = 1'b1;
                s_d.rsp.data = {8'h00, s_q.stb[7], s_q.srq, s_q.stb[5:0]};
            end
            CMD_ERR_RD:
            begin
                s_d.rsp.valid = 1'b1;
                s_d.rsp.data = pop ? s_q.fifo[s_q.head] : CODE_NONE;
            end
            // No answer owed; the data holds
            CMD_CLS, CMD_OPC, CMD_NONE:
            begin
                s_d.rsp.data = s_q.rsp.data;
            end
            default:
            begin
                s_d.rsp.data = s_q.rsp.data;
            end
        endcase
    end

    // State register; power-on latches the power event
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q.fifo <= '0;
            s_q.head <= '0;
            s_q.count <= '0;
            s_q.esr <= ESR_RESET;
            s_q.service_request_mask <= SRE_RESET;
            s_q.ese <= ESE_RESET;
            s_q.reason <= 1'b0;
            s_q.srq <= 1'b0;
            s_q.stb <= 8'h00;
            s_q.rsp.valid <= 1'b0;
            s_q.rsp.data <= 16'h0000;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign rsp = s_q.rsp;
    assign status_byte = s_q.stb;
    assign srq = s_q.srq;

endmodule : status_event_reporting

// ==== tb/remote_ctrl.sv ====
// Controller model issuing common commands and collecting answers
`timescale 1ns/1ps
module remote_ctrl
    import status_pkg::*;
(
    input wire logic clk,
    input wire rsp_s rsp,
    output cmd_s cmd
);
    // Idle until a command is asked for
    initial cmd = '{op: CMD_NONE, arg: 8'h00};

    // One command per call, held for exactly one taking edge
    task automatic issue(input cmd_e op, input logic [7:0] arg, output logic [15:0] data,
        output logic ok);
        @(posedge clk);
        #1 cmd = '{op: op, arg: arg};
        @(posedge clk);
        #1 cmd = '{op: CMD_NONE, arg: ~arg};
        // Answer stands one cycle only, so it is taken now or lost
        ok = (op inside {CMD_SRE_WR, CMD_ESE_WR, CMD_CLS, CMD_OPC}) || rsp.valid === 1'b1;
        data = rsp.data;
    endtask : issue
endmodule : remote_ctrl

// ==== tb/status_event_reporting_asserts.sv ====
// Port assertions of the status reporting core
`timescale 1ns/1ps
module status_checker
    import status_pkg::*;
#(
    parameter int DEPTH = EVQ_DEPTH,
    parameter logic [15:0] WAVE_CAPACITY = WAVE_CAP
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire cmd_s cmd,
    input wire err_s err,
    input wire chk_s chk,
    input wire logic query_error,
    input wire logic mav,
    input wire logic ques,
    input wire rsp_s rsp,
    input wire logic [7:0] status_byte,
    input wire logic srq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic rd_op;

    // Commands that owe an answer
    assign rd_op = cmd.op inside {CMD_SRE_RD, CMD_ESE_RD, CMD_ESR_RD, CMD_STB_RD, CMD_POLL,
        CMD_ERR_RD};

    rsp_timing_a: assert property (rd_op |=> rsp.valid)
        else $error("read command not answered");
    poll_bit_a: assert property (cmd.op == CMD_POLL
        |=> rsp.data[STB_RQS] == $past(srq))
        else $error("poll answer lost request bit");
    srq_fall_a: assert property ($fell(srq) |-> $past(cmd.op) == CMD_POLL)
        else $error("request flag cleared without poll");
    esr_bits_a: assert property (cmd.op == CMD_ESR_RD
        |=> rsp.data[6] == 1'b0 && !rsp.data[1])
        else $error("unused event bit reported");
    sre_readback_a: assert property (cmd.op == CMD_SRE_WR ##2 cmd.op == CMD_SRE_RD
        |=> rsp.data == {8'h00, $past(cmd.arg, 3) & SRE_WR_MASK})
        else $error("service mask read back wrong");
    evq_set_a: assert property (err.valid ##1 !(cmd.op inside {CMD_CLS, CMD_ERR_RD})
        |=> status_byte[STB_EVQ])
        else $error("queue summary missing");
    stb_lag_a: assert property ($past(rst_n) |-> status_byte[STB_MAV] == $past(mav)
        && status_byte[STB_QUES] == $past(ques))
        else $error("status levels not passed on");
    unused_bits_a: assert property (status_byte[7] == 1'b0
        && status_byte[1:0] == 2'h0)
        else $error("unused status bit set");
endmodule : status_checker

bind status_event_reporting status_checker #(.DEPTH(DEPTH), .WAVE_CAPACITY(WAVE_CAPACITY))
    i_chk (.clk(clk), .rst_n(rst_n), .cmd(cmd), .err(err), .chk(chk),
    .query_error(query_error), .mav(mav), .ques(ques), .rsp(rsp),
    .status_byte(status_byte), .srq(srq));

// ==== tb/tb.sv ====
// Self-checking bench of the status reporting core
`timescale 1ns/1ps
module tb;
    import status_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    cmd_s cmd;
    err_s err = '0;
    chk_s chk = '0;
    logic query_error = 1'b0;
    logic mav = 1'b0;
    logic ques = 1'b0;
    rsp_s rsp;
    logic [7:0] status_byte;
    logic srq;
    logic [15:0] rd;
    logic ok;
    int mismatches = 0;
    int check_count = 0;

    // 100 MHz clock
    always #5 clk = ~clk;

    remote_ctrl i_ctrl (.clk(clk), .rsp(rsp), .cmd(cmd));

    // Small capacity so the oversize check is reachable
    status_event_reporting #(.WAVE_CAPACITY(16'h0100)) i_dut (.clk(clk), .rst_n(rst_n),
        .cmd(cmd), .err(err), .chk(chk), .query_error(query_error), .mav(mav), .ques(ques),
        .rsp(rsp), .status_byte(status_byte), .srq(srq));

    task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val

    task automatic check_flag(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask : check_flag

    task automatic do_cmd(input cmd_e op, input logic [7:0] arg);
        i_ctrl.issue(op, arg, rd, ok);
    endtask : do_cmd

    task automatic ask(input cmd_e op, input logic [15:0] exp);
        i_ctrl.issue(op, 8'h00, rd, ok);
        check_flag("answer strobe", 1'b1, ok);
        check_val(op.name(), exp, rd);
    endtask : ask

    // Released fields show inverted data, not the last value
    task automatic put_err(input code_t code);
        @(posedge clk);
        #1 err = '{valid: 1'b1, code: code};
        @(posedge clk);
        #1 err = '{valid: 1'b0, code: ~code};
    endtask : put_err

    task automatic put_chk(input chk_e kind, input logic [15:0] value);
        @(posedge clk);
        #1 chk = '{valid: 1'b1, kind: kind, value: value};
        @(posedge clk);
        #1 chk = '{valid: 1'b0, kind: kind, value: ~value};
    endtask : put_chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic t_events();
        ask(CMD_ESR_RD, 16'h0080);
        ask(CMD_ESR_RD, 16'h0000);
        ask(CMD_ERR_RD, 16'h0000);
        do_cmd(CMD_OPC, 8'h00);
        ask(CMD_ESR_RD, 16'h0001);
        @(posedge clk);
        #1 query_error = 1'b1;
        @(posedge clk);
        #1 query_error = 1'b0;
        ask(CMD_ESR_RD, 16'h0004);
        put_err(-16'sh0071);
        ask(CMD_ESR_RD, 16'h0020);
        put_err(-16'sh00DE);
        ask(CMD_ESR_RD, 16'h0010);
        put_err(-16'sh013B);
        ask(CMD_ESR_RD, 16'h0008);
        check_flag("queue summary", 1'b1, status_byte[2]);
        ask(CMD_ERR_RD, -16'sh0071);
        ask(CMD_ERR_RD, -16'sh00DE);
        ask(CMD_ERR_RD, -16'sh013B);
        ask(CMD_ERR_RD, 16'h0000);
        tick(2);
        check_flag("queue summary", 1'b0, status_byte[2]);
        $display("t_events done");
    endtask : t_events

    // Each limit is tried at its edge first, then one past it
    task automatic t_limits();
        chk_e kinds[10] = '{CHK_MNEMONIC, CHK_SUFFIX, CHK_CHARDATA, CHK_EXPONENT, CHK_DIGITS,
            CHK_RANGES, CHK_PROTECT, CHK_WAVE_SIZE, CHK_CFG_MEM, CHK_SELFTEST};
        logic [15:0] lims[10] = '{16'h000C, 16'h000C, 16'h000C, 16'h7D00, 16'h00FF, 16'h0006,
            16'h0000, 16'h0100, 16'h0000, 16'h0000};
        code_t codes[10] = '{-16'sh0070, -16'sh0086, -16'sh0090, -16'sh007B, -16'sh007C,
            -16'sh00AA, -16'sh0102, -16'sh00DF, -16'sh013B, -16'sh014A};
        for (int i = 0; i < 10; i++)
        begin
            put_chk(kinds[i], lims[i]);
            put_chk(kinds[i], lims[i] + 16'h0001);
            ask(CMD_ERR_RD, codes[i]);
            ask(CMD_ERR_RD, 16'h0000);
        end
        $display("t_limits done");
    endtask : t_limits

    // Eleven unread codes back to back, one too many
    task automatic t_overflow();
        do_cmd(CMD_CLS, 8'h00);
        @(posedge clk);
        for (int i = 0; i < 11; i++)
        begin
            #1 err = '{valid: 1'b1, code: -16'sh0065 - code_t'(i)};
            @(posedge clk);
        end
        #1 err = '0;
        for (int i = 0; i < 9; i++)
            ask(CMD_ERR_RD, -16'sh0065 - code_t'(i));
        ask(CMD_ERR_RD, -16'sh015E);
        ask(CMD_ERR_RD, 16'h0000);
        $display("t_overflow done");
    endtask : t_overflow

    task automatic t_request();
        do_cmd(CMD_CLS, 8'h00);
        do_cmd(CMD_SRE_WR, 8'hFF);
        ask(CMD_SRE_RD, 16'h00BF);
        do_cmd(CMD_ESE_WR, 8'h20);
        ask(CMD_ESE_RD, 16'h0020);
        put_err(-16'sh0071);
        tick(3);
        check_val("status byte", 16'h0064, {8'h00, status_byte});
        check_flag("srq", 1'b1, srq);
        ask(CMD_POLL, 16'h0064);
        check_flag("srq", 1'b0, srq);
        ask(CMD_STB_RD, 16'h0064);
        mav = 1'b1;
        ques = 1'b1;
        tick(2);
        check_val("status byte", 16'h007C, {8'h00, status_byte});
        do_cmd(CMD_ESE_WR, 8'h00);
        do_cmd(CMD_CLS, 8'h00);
        tick(3);
        check_val("status byte", 16'h0058, {8'h00, status_byte});
        mav = 1'b0;
        ques = 1'b0;
        $display("t_request done");
    endtask : t_request

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish

    // Hang guard
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        tally_and_finish();
    end

    // Main sequence
    initial
    begin
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        t_events();
        t_limits();
        t_overflow();
        t_request();
        tally_and_finish();
    end
endmodule : tb
